// *** fsp_pkg.sv ***
// package for the isolated fast serial port: frame layout, buffer sizes, mode codes
// assumes one core clock mclk at 125 MHz; the serial clock comes from the peripheral
// Operation
// [R01] four wires: data in, clock in, data out, cts
// [R02] peripheral alone drives the serial clock
// [R03] serial clock is input; edges shift both ways
// [R04] receive bits on input-only data pin
// [R05] send bits on output-only data pin
// [R06] cts low only while transmit data ready
// [R07] suspended with wakeup enabled: strobe requests resume
// [R08] active: strobe flushes receive data next bulk-in
// [R09] unused strobe input held high by board
// [R10] port active only when fast serial mode selected
// [R11] receive data buffered, 1 kbyte, until host reads
// [R12] frame layout agreed from separate protocol definition
package fsp_pkg;
  // interface modes chosen by the host setup command
  typedef enum logic [1:0] {
    mode_uart = 2'b00,
    mode_fifo = 2'b01,
    mode_fast_serial = 2'b10,
    mode_bit_bang = 2'b11
  } port_mode_t;
  localparam int data_width = 8; // one byte per frame
  localparam int rx_buffer_bytes = 1024; // receive buffer depth
  localparam int link_fifo_depth = 16; // small buffer on the transmit path
  // frame: start bit (0), then data lsb first, then a stop bit (1)
  localparam int frame_bits = 10;
  localparam logic [3:0] frame_count_reset = 4'h0;
  localparam logic start_level = 1'b0;
  localparam logic idle_level = 1'b1;
  localparam logic [1:0] sync_reset = 2'h3; // pins idle high
endpackage

// *** fsp_stream_if.sv ***
// byte stream carrier between the port logic and its buffers
// assumes both ends sit on mclk
`timescale 1ns/1ps
interface fsp_stream_if #(parameter int width = 8);
  logic valid; // source holds a byte
  logic ready; // sink can take it
  logic [width-1:0] data; // the byte
  modport source (output valid, output data, input ready);
  modport sink (input valid, input data, output ready);
endinterface

// *** fsp_fifo.sv ***
// parameterised fifo with valid/ready on both sides; read data from a register
// assumes a single clock and an active-low asynchronous reset
`timescale 1ns/1ps
module fsp_fifo #(
  parameter int width = 8,
  parameter int depth = 16
) (
  input wire logic mclk,
  input wire logic nrst,
  fsp_stream_if.sink wr,
  fsp_stream_if.source rd,
  output logic [$clog2(depth):0] level
);
  import fsp_pkg::*;
  localparam int aw = $clog2(depth);
  logic [width-1:0] mem [depth]; // storage, no reset needed
  logic [aw:0] wp_q, wp_d, rp_q, rp_d; // pointers with wrap bit
  logic [width-1:0] out_q, out_d; // registered head
  logic out_v_q, out_v_d; // head register holds a byte
  logic push, pop_mem, empty_mem;
  //////////////////////////////////////////////////////////////////
  // full when pointers differ only in wrap bit; back-pressure to source
  assign empty_mem = (wp_q == rp_q);
  assign wr.ready = !((wp_q[aw] != rp_q[aw]) && (wp_q[aw-1:0] == rp_q[aw-1:0]));
  assign push = wr.valid && wr.ready;
  // refill the head register when it is empty or being taken
  assign pop_mem = !empty_mem && (!out_v_q || rd.ready);
  assign rd.valid = out_v_q;
  assign rd.data = out_q;
  assign level = (wp_q - rp_q) + {{aw{1'b0}}, out_v_q};
  // next-state for pointers and head
  always_comb begin
    wp_d = push ? wp_q + 1'b1 : wp_q;
    rp_d = pop_mem ? rp_q + 1'b1 : rp_q;
    out_d = pop_mem ? mem[rp_q[aw-1:0]] : out_q;
    out_v_d = pop_mem ? 1'b1 : (rd.ready ? 1'b0 : out_v_q);
  end
  // memory write has no reset on purpose
  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wp_q[aw-1:0]] <= wr.data;
    end
  end
  // register the pointers and head
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      wp_q <= '0;
      rp_q <= '0;
      out_q <= '0;
      out_v_q <= 1'b0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
      out_q <= out_d;
      out_v_q <= out_v_d;
    end
  end
endmodule // fsp_fifo

// *** isolated_fast_serial_port.sv ***
// isolated fast serial port: peripheral-clocked four-wire link to usb buffers
// assumes usb engine offers tx bytes by valid/ready and drains rx bytes likewise
`timescale 1ns/1ps
module isolated_fast_serial_port #(
  parameter int rx_depth = fsp_pkg::rx_buffer_bytes,
  parameter int tx_depth = fsp_pkg::link_fifo_depth
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire fsp_pkg::port_mode_t port_mode,
  input wire logic remote_wakeup_en,
  input wire logic power_enable_n,
  input wire logic iso_serial_data_in,
  input wire logic iso_serial_clock_in,
  input wire logic flush_or_wakeup_n,
  output logic iso_serial_data_out,
  output logic iso_clear_to_send_n,
  input wire logic tx_valid,
  input wire logic [fsp_pkg::data_width-1:0] tx_data,
  output logic tx_ready,
  output logic rx_valid,
  output logic [fsp_pkg::data_width-1:0] rx_data,
  input wire logic rx_ready,
  output logic rx_flush_req,
  output logic resume_req,
  output logic rx_overrun
);
  import fsp_pkg::*;
  //////////////////////////////////////////////////////////////////
  // two-flop synchronisers for every pin input [R03] [R04]
  // a pin may move on an mclk edge; the second flop absorbs that race
  logic [1:0] clk_s_q, din_s_q, flush_or_wakeup_n_s_q;
  logic sclk_last_q; // previous synced clock, for edge finding
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      clk_s_q <= sync_reset;
      din_s_q <= sync_reset;
      flush_or_wakeup_n_s_q <= sync_reset;
      sclk_last_q <= idle_level;
    end else begin
      clk_s_q <= {clk_s_q[0], iso_serial_clock_in};
      din_s_q <= {din_s_q[0], iso_serial_data_in};
      flush_or_wakeup_n_s_q <= {flush_or_wakeup_n_s_q[0], flush_or_wakeup_n};
      sclk_last_q <= clk_s_q[1];
    end
  end
  logic enabled, rise, fall, sclk, din;
  assign sclk = clk_s_q[1];
  assign din = din_s_q[1];
  assign enabled = (port_mode == mode_fast_serial); // [R10]
  // rising edge samples data in, falling edge moves data out [R03]
  assign rise = enabled && sclk && !sclk_last_q;
  assign fall = enabled && !sclk && sclk_last_q;
  //////////////////////////////////////////////////////////////////
  // buffers: transmit path 16 deep, receive path 1 kbyte [R11]
  fsp_stream_if #(.width(data_width)) tx_in ();
  fsp_stream_if #(.width(data_width)) tx_out ();
  fsp_stream_if #(.width(data_width)) rx_in ();
  fsp_stream_if #(.width(data_width)) rx_out ();
  assign tx_in.valid = tx_valid;
  assign tx_in.data = tx_data;
  assign tx_ready = tx_in.ready; // usb engine stalls when full
  assign rx_valid = rx_out.valid;
  assign rx_data = rx_out.data;
  assign rx_out.ready = rx_ready;
  fsp_fifo #(.width(data_width), .depth(tx_depth)) u_tx_fifo (
    .mclk(mclk),
    .nrst(nrst),
    .wr(tx_in),
    .rd(tx_out),
    .level()
  );
  fsp_fifo #(.width(data_width), .depth(rx_depth)) u_rx_fifo (
    .mclk(mclk),
    .nrst(nrst),
    .wr(rx_in),
    .rd(rx_out),
    .level()
  );
  //////////////////////////////////////////////////////////////////
  // receiver: start bit, 8 data bits lsb first, stop bit [R12]
  logic [3:0] rcnt_q, rcnt_d; // bit position, 0 = hunting start
  logic [data_width-1:0] rsh_q, rsh_d; // shift register
  logic rvalid_q, rvalid_d; // byte waiting for the rx buffer
  logic ovr_q, ovr_d; // sticky overrun, byte lost
  assign rx_in.valid = rvalid_q;
  assign rx_in.data = rsh_q;
  assign rx_overrun = ovr_q;
  // receive next-state
  // the holding register gives one byte of slack before an overrun
  always_comb begin
    rcnt_d = rcnt_q;
    rsh_d = rsh_q;
    rvalid_d = rvalid_q && !rx_in.ready;
    ovr_d = ovr_q;
    if (!enabled) begin
      rcnt_d = frame_count_reset;
    end else if (rise) begin // [R04]
      if (rcnt_q == frame_count_reset) begin
        if (din == start_level) begin
          rcnt_d = 4'h1;
        end
      end else if (rcnt_q == 4'(frame_bits - 1)) begin
        rcnt_d = frame_count_reset;
        // a framing error (stop low) drops the byte
        if (din == idle_level) begin
          if (rvalid_d) begin
            ovr_d = 1'b1; // buffer still stalled: the newer byte, shifted over the earlier one, stays held
          end else begin
            rvalid_d = 1'b1;
          end
        end
      end else begin
        rsh_d = {din, rsh_q[data_width-1:1]};
        rcnt_d = rcnt_q + 4'h1;
      end
    end
  end
  // receive registers
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rcnt_q <= frame_count_reset;
      rsh_q <= '0;
      rvalid_q <= 1'b0;
      ovr_q <= 1'b0;
    end else begin
      rcnt_q <= rcnt_d;
      rsh_q <= rsh_d;
      rvalid_q <= rvalid_d;
      ovr_q <= ovr_d;
    end
  end
  //////////////////////////////////////////////////////////////////
  // transmitter: loads a byte, then shifts a frame on falling edges
  typedef enum logic [1:0] {
    tx_idle = 2'b00,
    tx_shift = 2'b01
  } tx_state_t;
  tx_state_t tst_q, tst_d;
  logic [frame_bits-1:0] tsh_q, tsh_d; // frame incl. start/stop
  logic [3:0] tcnt_q, tcnt_d; // bits left
  logic dout_q, dout_d; // registered data pin [R05]
  logic cts_n_q, cts_n_d; // registered clear-to-send
  assign tx_out.ready = enabled && (tst_q == tx_idle) && fall;
  // transmit next-state
  // bytes leave only on a detected fall, so a parked clock keeps them queued
  always_comb begin
    tst_d = tst_q;
    tsh_d = tsh_q;
    tcnt_d = tcnt_q;
    dout_d = dout_q;
    // low only when a byte is waiting or in flight [R06]
    cts_n_d = !(enabled && (tx_out.valid || tst_q == tx_shift));
    unique case (tst_q)
      tx_idle: begin
        dout_d = idle_level;
        if (tx_out.valid && tx_out.ready) begin // peripheral clock paces us [R03]
          tsh_d = {idle_level, tx_out.data, start_level};
          dout_d = start_level;
          tcnt_d = 4'(frame_bits - 1);
          tst_d = tx_shift;
        end
      end
      tx_shift: begin
        if (!enabled) begin
          tst_d = tx_idle;
          dout_d = idle_level;
        end else if (fall) begin
          tsh_d = {idle_level, tsh_q[frame_bits-1:1]};
          dout_d = tsh_q[1];
          tcnt_d = tcnt_q - 4'h1;
          if (tcnt_q == 4'h1) begin
            tst_d = tx_idle;
          end
        end
      end
    endcase
  end
  // transmit registers
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      tst_q <= tx_idle;
      tsh_q <= '1;
      tcnt_q <= frame_count_reset;
      dout_q <= idle_level;
      cts_n_q <= 1'b1;
    end else begin
      tst_q <= tst_d;
      tsh_q <= tsh_d;
      tcnt_q <= tcnt_d;
      dout_q <= dout_d;
      cts_n_q <= cts_n_d;
    end
  end
  // only two outputs on the link; the clock pin is never driven [R01] [R02]
  assign iso_serial_data_out = dout_q;
  assign iso_clear_to_send_n = cts_n_q;
  //////////////////////////////////////////////////////////////////
  // strobe on the flush/wakeup input; an idle high input is harmless [R09]
  logic flush_or_wakeup_n_last_q, flush_q, flush_d, resume_q, resume_d;
  logic strobe;
  assign strobe = enabled && !flush_or_wakeup_n_s_q[1] && flush_or_wakeup_n_last_q;
  // pick function from power state
  always_comb begin
    resume_d = strobe && power_enable_n && remote_wakeup_en; // [R07]
    flush_d = strobe && !power_enable_n; // [R08]
  end
  // strobe registers
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      flush_or_wakeup_n_last_q <= idle_level;
      flush_q <= 1'b0;
      resume_q <= 1'b0;
    end else begin
      flush_or_wakeup_n_last_q <= flush_or_wakeup_n_s_q[1];
      flush_q <= flush_d;
      resume_q <= resume_d;
    end
  end
  assign rx_flush_req = flush_q;
  assign resume_req = resume_q;
endmodule // isolated_fast_serial_port

// *** isolated_fast_serial_port_assertions.sv ***
// checker bound to the fast serial port top
// assumes one mclk domain and active-low nrst
`timescale 1ns/1ps
module fsp_chk (
  input wire logic mclk,
  input wire logic nrst,
  input wire fsp_pkg::port_mode_t port_mode,
  input wire logic remote_wakeup_en,
  input wire logic power_enable_n,
  input wire logic iso_serial_clock_in,
  input wire logic flush_or_wakeup_n,
  input wire logic iso_serial_data_out,
  input wire logic iso_clear_to_send_n,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic rx_valid,
  input wire logic [fsp_pkg::data_width-1:0] rx_data,
  input wire logic rx_ready,
  input wire logic rx_flush_req,
  input wire logic resume_req
);
  import fsp_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  logic [3:0] wr_q; // accepted tx bytes, last four cycles
  logic [3:0] wr_d;
  always_comb wr_d = {wr_q[2:0], tx_valid & tx_ready};
  // history only; reset clears it so cts cannot lean on old writes
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) wr_q <= 4'h0;
    else wr_q <= wr_d;
  end
  a_cts_needs_byte: assert property ($fell(iso_clear_to_send_n) |-> |wr_q)
    else $error("cts fell with no byte");
  a_idle_out_high: assert property (iso_clear_to_send_n |-> iso_serial_data_out)
    else $error("data out low when idle");
  a_shift_on_fall: assert property ($changed(iso_serial_data_out) |-> !iso_serial_clock_in)
    else $error("data out moved off a fall");
  a_mode_gate: assert property (port_mode != mode_fast_serial |-> !$rose(rx_valid))
    else $error("byte taken in other mode");
  a_resume_cond: assert property (resume_req |-> power_enable_n && remote_wakeup_en)
    else $error("resume not allowed");
  a_flush_cond: assert property (rx_flush_req |-> !power_enable_n)
    else $error("flush in suspend");
  a_strobe_pulse: assert property (rx_flush_req || resume_req |->
    !$past(flush_or_wakeup_n, 2) ##1 !(rx_flush_req || resume_req))
    else $error("pulse without strobe");
  a_rx_holds: assert property (rx_valid && !rx_ready |=> rx_valid && $stable(rx_data))
    else $error("rx byte not held");
endmodule // fsp_chk
bind isolated_fast_serial_port fsp_chk fsp_chk_inst (.mclk, .nrst, .port_mode,
  .remote_wakeup_en, .power_enable_n, .iso_serial_clock_in, .flush_or_wakeup_n,
  .iso_serial_data_out, .iso_clear_to_send_n, .tx_valid, .tx_ready, .rx_valid, .rx_data,
  .rx_ready, .rx_flush_req, .resume_req);

// *** fsp_peripheral_model.sv ***
// isolated peripheral: makes the serial clock, drives data in, reads data out
// assumes 125 ns bits, ten per frame, clock parked high between frames
`timescale 1ns/1ps
module fsp_peripheral_model (
  output logic iso_serial_clock_in,
  output logic iso_serial_data_in,
  input wire logic iso_serial_data_out,
  input wire logic iso_clear_to_send_n
);
  // only this side owns the clock
  initial begin
    iso_serial_clock_in = 1'b1;
    iso_serial_data_in = 1'b1;
  end
  // start, lsb first, stop; set on fall, read on rise
  task automatic xfer(input logic [7:0] b, output logic [7:0] g);
    logic [9:0] f;
    logic [9:0] r;
    f = {1'b1, b, 1'b0};
    for (int k = 0; k < 10; k++) begin
      iso_serial_clock_in = 1'b0;
      iso_serial_data_in = f[k];
      #62.5;
      iso_serial_clock_in = 1'b1;
      r[k] = iso_serial_data_out;
      #62.5;
    end
    g = r[8:1];
    // released: show the inverse, never a held value
    iso_serial_data_in = ~f[9];
  endtask
endmodule // fsp_peripheral_model

// *** test_isolated_fast_serial_port.sv ***
// bench for the fast serial port with the peripheral model
// assumes 125 MHz mclk; small rx buffer to reach overrun quickly
`timescale 1ns/1ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin bad_count++; \
  $display("[FAIL] %0t %h %h", $time, (a), (e)); end end
`define WAITF(c) for (w = 0; w < 4000 && !(c); w++) @(negedge mclk); \
  if (!(c)) begin bad_count++; $display("[FAIL] %0t %h %h", $time, w, 4000); end_sim(); end
module test_isolated_fast_serial_port;
  import fsp_pkg::*;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  port_mode_t port_mode = mode_fast_serial;
  logic remote_wakeup_en = 1'b0;
  logic power_enable_n = 1'b0;
  logic flush_or_wakeup_n = 1'b1; // parked high when unused
  logic tx_valid = 1'b0;
  logic [7:0] tx_data = 8'h00;
  logic rx_ready = 1'b0;
  logic iso_serial_data_in, iso_serial_clock_in, iso_serial_data_out, iso_clear_to_send_n;
  logic tx_ready, rx_valid, rx_flush_req, resume_req, rx_overrun;
  logic [7:0] rx_data, g;
  int bad_count = 0, check_count = 0, w, i, n;
  integer fr, rs; // four-state so an unknown pulse cannot count as zero
  isolated_fast_serial_port #(.rx_depth(4), .tx_depth(16)) isolated_fast_serial_port_inst (
    .mclk, .nrst, .port_mode, .remote_wakeup_en, .power_enable_n, .iso_serial_data_in,
    .iso_serial_clock_in, .flush_or_wakeup_n, .iso_serial_data_out, .iso_clear_to_send_n,
    .tx_valid, .tx_data, .tx_ready, .rx_valid, .rx_data, .rx_ready, .rx_flush_req,
    .resume_req, .rx_overrun);
  fsp_peripheral_model fsp_peripheral_model_inst (.iso_serial_clock_in, .iso_serial_data_in,
    .iso_serial_data_out, .iso_clear_to_send_n);
  always #4 mclk = ~mclk;
  task automatic end_sim();
    if (bad_count == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // offer up to lim bytes; n counts those taken, a refused one is withdrawn
  task automatic fill_tx(input int lim);
    for (n = 0; n < lim; n++) begin
      @(posedge mclk);
      tx_valid <= 1'b1;
      tx_data <= {n[3:0], ~n[3:0]};
      @(negedge mclk);
      if (!tx_ready) break;
    end
    @(posedge mclk);
    tx_valid <= 1'b0;
    @(negedge mclk);
  endtask
  task automatic get_rx(input logic [7:0] e);
    `WAITF(rx_valid)
    `CHK(rx_data, e)
    @(posedge mclk);
    rx_ready <= 1'b1;
    @(posedge mclk);
    rx_ready <= 1'b0;
    @(negedge mclk);
  endtask
  task automatic t_duplex();
    `CHK({iso_clear_to_send_n, iso_serial_data_out, rx_valid, tx_ready}, 4'hd)
    fill_tx(2);
    `WAITF(!iso_clear_to_send_n)
    for (i = 0; i < 2; i++) begin
      `CHK(iso_clear_to_send_n, 1'b0)
      fsp_peripheral_model_inst.xfer(8'ha5 ^ i[7:0], g);
      `CHK(g, {i[3:0], ~i[3:0]})
      get_rx(8'ha5 ^ i[7:0]);
    end
    `WAITF(iso_clear_to_send_n)
  endtask
  // every other mode must ignore the link
  task automatic t_modes();
    for (i = 0; i < 4; i++) begin
      if (i == 2) continue;
      @(posedge mclk);
      port_mode <= port_mode_t'(i[1:0]);
      fsp_peripheral_model_inst.xfer(8'h3c, g);
      repeat (20) @(negedge mclk);
      `CHK(rx_valid, 1'b0)
      `CHK(g, 8'hff)
      `CHK(iso_clear_to_send_n, 1'b1)
    end
    @(posedge mclk);
    port_mode <= mode_fast_serial;
  endtask
  task automatic t_strobe(input logic p, input logic we, input int ef, input int er);
    fr = 0;
    rs = 0;
    for (w = 0; w < 16; w++) begin
      @(posedge mclk);
      power_enable_n <= p;
      remote_wakeup_en <= we;
      flush_or_wakeup_n <= (w >= 8);
      @(negedge mclk);
      fr += rx_flush_req;
      rs += resume_req;
    end
    `CHK(fr, ef)
    `CHK(rs, er)
  endtask
  // tx buffer to full, drained while rx stalls and overruns
  task automatic t_fill();
    fill_tx(20);
    `CHK(tx_ready, 1'b0)
    for (i = 0; i < n; i++) begin
      fsp_peripheral_model_inst.xfer(i[7:0], g);
      `CHK(g, {i[3:0], ~i[3:0]})
    end
    `CHK(rx_overrun, 1'b1)
    for (i = 0; i < 4; i++) get_rx(i[7:0]);
    `WAITF(iso_clear_to_send_n)
  endtask
  initial begin
    repeat (8) @(posedge mclk);
    nrst <= 1'b1;
    @(negedge mclk);
    t_duplex();
    t_modes();
    t_strobe(1'b1, 1'b1, 0, 1);
    t_strobe(1'b1, 1'b0, 0, 0);
    t_strobe(1'b0, 1'b1, 1, 0);
    t_fill();
    end_sim();
  end
endmodule // test_isolated_fast_serial_port
